// *** flash_dev_model.sv ***
`timescale 1ns/1ps
// ****************************************
// behavioural flash device
// ****************************************
module flash_dev_model (
    // clock and pins
    input  wire logic                          ref_clk,
    input  wire flash_host_pkg::pins_t         pins,
    output logic [flash_host_pkg::DATA_W-1:0]  flashDin,
    // algorithm control
    input  wire logic                          algoGo,
    input  wire logic                          algoErase,
    input  wire logic [15:0]                   algoReads
);
    logic        busy_q   = 1'h0;
    logic        erase_q  = 1'h0;
    logic        tog_q    = 1'h0;
    logic        cePrev_q = 1'h1;
    logic [15:0] left_q   = 16'h0;
    logic [6:0]  sect_q   = 7'h7F;
    logic [7:0]  data_q   = 8'h00;
    logic [7:0]  arr_q    = 8'h00;
    logic [7:0]  out_q    = 8'h00;
    wire logic       drive   = !pins.ceN && !pins.oeN;
    wire logic       rdStart = drive && cePrev_q;
    wire logic       inSect  = pins.addr[18:12] == sect_q;
    wire logic [7:0] arrVal  = inSect ? arr_q : pins.addr[7:0];
    wire logic [7:0] stat    = {erase_q ? 1'h0 : ~data_q[7], ~tog_q, 6'h00};
    // released bus shows the inverse of the last byte
    assign flashDin = drive ? out_q : ~out_q;
    always_ff @(posedge ref_clk) begin
        cePrev_q <= pins.ceN;
        if (!pins.rstN) begin
            busy_q <= 1'h0;
        end else if (algoGo) begin
            busy_q  <= 1'h1;
            erase_q <= algoErase;
            left_q  <= algoReads;
        end else if (rdStart) begin
            out_q <= busy_q ? stat : arrVal;
            if (busy_q) begin
                tog_q  <= ~tog_q;
                left_q <= left_q - 16'h1;
                busy_q <= left_q != 16'h1;
                if (left_q == 16'h1) arr_q <= erase_q ? 8'hFF : data_q;
            end
        end
        if (!pins.weN && !pins.ceN && pins.doutEn) begin
            sect_q <= pins.addr[18:12];
            data_q <= pins.dout;
        end
    end
endmodule // flash_dev_model

// *** flash_host.sv ***
`timescale 1ns/1ps
module flash_host #(
    parameter int RST_BUSY_CYC = flash_host_pkg::RST_BUSY_CYC,
    parameter int PROT_CYC     = flash_host_pkg::PROT_CYC,
    parameter int UNPROT_CYC   = flash_host_pkg::UNPROT_CYC,
    parameter int SUSP_A_CYC   = flash_host_pkg::SUSP_A_CYC,
    parameter int SUSP_B_CYC   = flash_host_pkg::SUSP_B_CYC,
    parameter int POLL_MAX     = 65535
) (
    // clock and reset
    input  wire logic                                ref_clk,
    input  wire logic                                sys_rst,
    // request side
    input  wire logic                                reqValid,
    input  wire flash_host_pkg::req_t                req,
    output logic                                     reqReady,
    output logic                                     doneValid,
    output logic [flash_host_pkg::DATA_W-1:0]        doneData,
    output logic                                     doneOk,
    // flash pins
    output flash_host_pkg::pins_t                    pins,
    input  wire logic [flash_host_pkg::DATA_W-1:0]   flashDin
);

    // ****************************************
    // input synchroniser
    // ****************************************
    logic [flash_host_pkg::DATA_W-1:0] dinMeta_q;
    logic [flash_host_pkg::DATA_W-1:0] dinSync_q;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dinMeta_q <= '0;
            dinSync_q <= '0;
        end else begin
            dinMeta_q <= flashDin;
            dinSync_q <= dinMeta_q;
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    flash_host_pkg::state_t            state_q;
    flash_host_pkg::state_t            ret_q;
    flash_host_pkg::req_t              cur_q;
    flash_host_pkg::pins_t             pins_q;
    logic [flash_host_pkg::CNT_W-1:0]  cnt_q;
    logic [flash_host_pkg::CNT_W-1:0]  polls_q;
    logic [10:0]                       susp_q;
    logic                              prevTgl_q;
    logic                              havePrev_q;
    logic                              rstBusy_q;
    logic                              doneValid_q;
    logic                              doneOk_q;
    logic [flash_host_pkg::DATA_W-1:0] doneData_q;
    logic [flash_host_pkg::DATA_W-1:0] statByte_q;

    localparam int RDC = 4;
    wire cntZero   = (cnt_q == '0);
    // released bus is not status: poll on the byte latched at read end
    wire pollBit   = statByte_q[flash_host_pkg::POLL_BIT];
    wire tglBit    = statByte_q[flash_host_pkg::TOGGLE_BIT];
    wire progDone  = (pollBit == cur_q.data[flash_host_pkg::POLL_BIT]);
    wire erasDone  = pollBit;
    wire tglDone   = havePrev_q && (tglBit == prevTgl_q);
    wire isProg    = (cur_q.op == flash_host_pkg::OP_POLL_PROG);
    wire isEras    = (cur_q.op == flash_host_pkg::OP_POLL_ERAS);
    wire statDone  = isProg ? progDone : (isEras ? erasDone : tglDone);
    wire suspOver  = (susp_q >= 11'(flash_host_pkg::SUSP_LIMIT));
    wire pollOut   = (polls_q >= POLL_MAX[flash_host_pkg::CNT_W-1:0]);
    wire [flash_host_pkg::ADDR_W-1:0] sectAddr = {req.addr[flash_host_pkg::SECT_HI:
        flash_host_pkg::SECT_LO], {flash_host_pkg::SECT_LO{1'b0}}};

    assign reqReady  = (state_q == flash_host_pkg::S_IDLE);
    assign pins      = pins_q;
    assign doneValid = doneValid_q;
    assign doneOk    = doneOk_q;
    assign doneData  = doneData_q;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q     <= flash_host_pkg::S_IDLE;
            ret_q       <= flash_host_pkg::S_IDLE;
            cur_q       <= '0;
            pins_q      <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, rstN: 1'b1, default: '0};
            cnt_q       <= '0;
            polls_q     <= '0;
            susp_q      <= '0;
            prevTgl_q   <= 1'b0;
            havePrev_q  <= 1'b0;
            rstBusy_q   <= 1'b0;
            doneValid_q <= 1'b0;
            doneOk_q    <= 1'b0;
            doneData_q  <= '0;
            statByte_q  <= '0;
        end else begin
            doneValid_q <= 1'b0;
            if (!cntZero) begin
                cnt_q <= cnt_q - 1'b1;
            end
            case (state_q)
                flash_host_pkg::S_IDLE: begin
                    if (reqValid) begin
                        cur_q      <= req;
                        polls_q    <= '0;
                        havePrev_q <= 1'b0;
                        pins_q.addr <= req.addr;
                        case (req.op)
                            flash_host_pkg::OP_READ, flash_host_pkg::OP_POLL_PROG,
                            flash_host_pkg::OP_POLL_ERAS, flash_host_pkg::OP_TOGGLE: begin
                                pins_q.ceN <= 1'b0;
                                pins_q.oeN <= 1'b0;
                                cnt_q      <= RDC;
                                state_q    <= flash_host_pkg::S_RD;
                            end
                            flash_host_pkg::OP_WRITE: begin
                                if (req.suspend && suspOver) begin
                                    cnt_q   <= req.variantB ? SUSP_B_CYC : SUSP_A_CYC;
                                    susp_q  <= '0;
                                    state_q <= flash_host_pkg::S_SUSPD;
                                end else begin
                                    if (req.suspend) begin
                                        susp_q <= susp_q + 1'b1;
                                    end
                                    pins_q.ceN    <= 1'b0;
                                    pins_q.weN    <= 1'b0;
                                    pins_q.dout   <= req.data;
                                    pins_q.doutEn <= 1'b1;
                                    cnt_q         <= RDC;
                                    state_q       <= flash_host_pkg::S_WR;
                                end
                                pins_q.addr <= req.addr;
                            end
                            flash_host_pkg::OP_RESET: begin
                                pins_q.rstN <= 1'b0;
                                rstBusy_q   <= req.devBusy;
                                cnt_q       <= flash_host_pkg::RST_PULSE_CYC;
                                state_q     <= flash_host_pkg::S_RSTLO;
                            end
                            default: begin
                                // protect and unprotect under high voltage
                                pins_q.addr  <= sectAddr;
                                pins_q.ceN   <= 1'b0;
                                pins_q.rstHv <= 1'b1;
                                pins_q.oeHv  <= 1'b1;
                                cnt_q        <= flash_host_pkg::HV_SETUP_CYC;
                                state_q      <= flash_host_pkg::S_HVSET;
                            end
                        endcase
                    end
                end
                flash_host_pkg::S_RD: begin
                    if (cntZero) begin
                        pins_q.ceN <= 1'b1;
                        pins_q.oeN <= 1'b1;
                        cnt_q      <= flash_host_pkg::CS_HIGH_CYC;
                        if (cur_q.op == flash_host_pkg::OP_READ) begin
                            doneData_q  <= dinSync_q;
                            doneOk_q    <= 1'b1;
                            doneValid_q <= 1'b1;
                            ret_q       <= flash_host_pkg::S_IDLE;
                        end else begin
                            statByte_q <= dinSync_q;
                            ret_q      <= flash_host_pkg::S_POLL;
                        end
                        state_q <= flash_host_pkg::S_GAP;
                    end
                end
                flash_host_pkg::S_POLL: begin
                    // no verify step: completion status is final
                    prevTgl_q  <= tglBit;
                    havePrev_q <= 1'b1;
                    polls_q    <= polls_q + 1'b1;
                    if (statDone || pollOut) begin
                        doneData_q  <= statByte_q;
                        doneOk_q    <= statDone;
                        doneValid_q <= 1'b1;
                        state_q     <= flash_host_pkg::S_IDLE;
                    end else begin
                        pins_q.ceN <= 1'b0;
                        pins_q.oeN <= 1'b0;
                        cnt_q      <= RDC;
                        state_q    <= flash_host_pkg::S_RD;
                    end
                end
                flash_host_pkg::S_WR: begin
                    if (cntZero) begin
                        pins_q.ceN    <= 1'b1;
                        pins_q.weN    <= 1'b1;
                        pins_q.doutEn <= 1'b0;
                        cnt_q         <= flash_host_pkg::CS_HIGH_CYC;
                        doneOk_q      <= 1'b1;
                        doneValid_q   <= 1'b1;
                        ret_q         <= flash_host_pkg::S_IDLE;
                        state_q       <= flash_host_pkg::S_GAP;
                    end
                end
                flash_host_pkg::S_GAP: begin
                    if (cntZero) begin
                        state_q <= ret_q;
                    end
                end
                flash_host_pkg::S_RSTLO: begin
                    if (cntZero) begin
                        pins_q.rstN <= 1'b1;
                        cnt_q <= rstBusy_q ? RST_BUSY_CYC :
                                 flash_host_pkg::RST_IDLE_CYC + flash_host_pkg::RST_READ_CYC;
                        state_q <= flash_host_pkg::S_RSTWT;
                    end
                end
                flash_host_pkg::S_RSTWT, flash_host_pkg::S_SUSPD: begin
                    if (cntZero) begin
                        doneOk_q    <= 1'b1;
                        doneValid_q <= 1'b1;
                        state_q     <= flash_host_pkg::S_IDLE;
                    end
                end
                flash_host_pkg::S_HVSET: begin
                    if (cntZero) begin
                        pins_q.weN <= 1'b0;
                        cnt_q <= (cur_q.op == flash_host_pkg::OP_PROTECT) ? PROT_CYC
                                                                          : UNPROT_CYC;
                        state_q <= flash_host_pkg::S_WEPUL;
                    end
                end
                flash_host_pkg::S_WEPUL: begin
                    if (cntZero) begin
                        pins_q.weN <= 1'b1;
                        cnt_q      <= flash_host_pkg::HV_SETUP_CYC;
                        state_q    <= flash_host_pkg::S_HVEND;
                    end
                end
                flash_host_pkg::S_HVEND: begin
                    if (cntZero) begin
                        pins_q.ceN   <= 1'b1;
                        pins_q.rstHv <= 1'b0;
                        pins_q.oeHv  <= 1'b0;
                        doneOk_q     <= 1'b1;
                        doneValid_q  <= 1'b1;
                        state_q      <= flash_host_pkg::S_IDLE;
                    end
                end
                default: begin
                    state_q <= flash_host_pkg::S_IDLE;
                end
            endcase
        end
    end

endmodule // flash_host

// *** flash_host_assertions.sv ***
`timescale 1ns/1ps
// ****************************************
// host pin sequencing checks
// ****************************************
module flash_host_checker #(
    parameter int PROT_CYC   = flash_host_pkg::PROT_CYC,
    parameter int UNPROT_CYC = flash_host_pkg::UNPROT_CYC
) (
    // clock and reset
    input  wire logic                              ref_clk,
    input  wire logic                              sys_rst,
    // request side
    input  wire logic                              reqValid,
    input  wire flash_host_pkg::req_t              req,
    input  wire logic                              reqReady,
    input  wire logic                              doneValid,
    input  wire logic [flash_host_pkg::DATA_W-1:0] doneData,
    input  wire logic                              doneOk,
    // flash pins
    input  wire flash_host_pkg::pins_t             pins,
    input  wire logic [flash_host_pkg::DATA_W-1:0] flashDin
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    int                  hvCnt_q;
    int                  weLow_q;
    int                  rstLow_q;
    flash_host_pkg::op_t lastOp_q;
    logic [7:0]          lastData_q;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hvCnt_q    <= 0;
            weLow_q    <= 0;
            rstLow_q   <= 0;
            lastOp_q   <= flash_host_pkg::OP_READ;
            lastData_q <= 8'h00;
        end else begin
            hvCnt_q  <= (pins.rstHv || pins.oeHv) ? hvCnt_q + 1 : 0;
            weLow_q  <= pins.weN ? 0 : weLow_q + 1;
            rstLow_q <= pins.rstN ? 0 : rstLow_q + 1;
            if (reqValid && reqReady) begin
                lastOp_q   <= req.op;
                lastData_q <= req.data;
            end
        end
    end
    a_cs_per_read: assert property ($fell(pins.oeN) && !pins.oeHv |-> $fell(pins.ceN))
        else $error("read started without a chip select edge");
    a_addr_held: assert property (!pins.ceN && !$past(pins.ceN) |-> $stable(pins.addr))
        else $error("address moved inside an access");
    a_rst_low_min: assert property ($rose(pins.rstN) |->
        rstLow_q >= flash_host_pkg::RST_PULSE_CYC)
        else $error("reset pulse too short");
    a_read_after_rst: assert property ($rose(pins.rstN) |-> pins.oeN [*2])
        else $error("read too soon after reset release");
    a_rst_hv_setup: assert property ($fell(pins.weN) && pins.rstHv |->
        hvCnt_q >= flash_host_pkg::HV_SETUP_CYC)
        else $error("write too soon after reset high voltage");
    a_oe_hv_setup: assert property ($fell(pins.weN) && pins.oeHv |->
        hvCnt_q >= flash_host_pkg::HV_SETUP_CYC)
        else $error("write enable too soon after output enable setup");
    a_prot_pulse: assert property ($rose(pins.weN) && lastOp_q == flash_host_pkg::OP_PROTECT
        |-> weLow_q >= PROT_CYC)
        else $error("protect write pulse too short");
    a_unprot_pulse: assert property ($rose(pins.weN) && lastOp_q == flash_host_pkg::OP_UNPROTECT
        |-> weLow_q >= UNPROT_CYC)
        else $error("unprotect write pulse too short");
    a_prog_poll_bit: assert property (doneValid && doneOk && lastOp_q ==
        flash_host_pkg::OP_POLL_PROG |-> doneData[7] == lastData_q[7])
        else $error("program poll ended on wrong bit");
    a_erase_poll_bit: assert property (doneValid && doneOk && lastOp_q ==
        flash_host_pkg::OP_POLL_ERAS |-> doneData[7])
        else $error("erase poll ended before erase finished");
    cover property (doneValid && !doneOk);
    cover property ($rose(pins.weN) && pins.oeHv);
    cover property ($rose(pins.rstN));
endmodule // flash_host_checker

bind flash_host flash_host_checker #(.PROT_CYC(PROT_CYC), .UNPROT_CYC(UNPROT_CYC)) chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reqValid(reqValid), .req(req),
    .reqReady(reqReady), .doneValid(doneValid), .doneData(doneData), .doneOk(doneOk),
    .pins(pins), .flashDin(flashDin));

// *** flash_host_pkg.sv ***
package flash_host_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_PS     = 25000;
    localparam int RST_PULSE_NS      = 500;
    localparam int RST_READY_BUSY_US = 20;
    localparam int RST_READY_IDLE_NS = 500;
    localparam int RST_TO_READ_NS    = 50;
    localparam int HV_SETUP_US       = 4;
    localparam int WE_MIN_NS         = 100;
    localparam int PROT_PULSE_US     = 10;
    localparam int UNPROT_PULSE_MS   = 12;
    localparam int SUSP_LIMIT        = 1024;
    localparam int SUSP_DELAY_A_US   = 10000;
    localparam int SUSP_DELAY_B_US   = 1500;
    localparam int CS_HIGH_CYC       = 2;

    // least reset, setup and write-enable times round up; protect, unprotect and suspend counts truncate
    localparam int RST_PULSE_CYC = (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RST_BUSY_CYC  = (RST_READY_BUSY_US * 1000000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
    localparam int RST_IDLE_CYC  = (RST_READY_IDLE_NS * 1000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
    localparam int RST_READ_CYC  = (RST_TO_READ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HV_SETUP_CYC  = (HV_SETUP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WE_MIN_CYC    = (WE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PROT_CYC      = (PROT_PULSE_US * 1000000) / CLK_PERIOD_PS;
    localparam int UNPROT_CYC    = (UNPROT_PULSE_MS * 1000000) / CLK_PERIOD_PS * 1000;
    localparam int SUSP_A_CYC    = (SUSP_DELAY_A_US * 1000) / CLK_PERIOD_PS * 1000;
    localparam int SUSP_B_CYC    = (SUSP_DELAY_B_US * 1000) / CLK_PERIOD_PS * 1000;

    // ****************************************
    // data bits and fields
    // ****************************************
    localparam int POLL_BIT      = 7;
    localparam int TOGGLE_BIT    = 6;
    localparam int ADDR_W        = 19;
    localparam int DATA_W        = 8;
    localparam int SECT_LO       = 12;
    localparam int SECT_HI       = 18;
    localparam int CNT_W         = 32;

    // ****************************************
    // host operations
    // ****************************************
    typedef enum logic [2:0] {
        OP_READ      = 3'h0,
        OP_WRITE     = 3'h1,
        OP_POLL_PROG = 3'h2,
        OP_POLL_ERAS = 3'h3,
        OP_TOGGLE    = 3'h4,
        OP_RESET     = 3'h5,
        OP_PROTECT   = 3'h6,
        OP_UNPROTECT = 3'h7
    } op_t;

    typedef struct packed {
        op_t               op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic              suspend;
        logic              variantB;
        logic              devBusy;
    } req_t;

    typedef struct packed {
        logic              ceN;
        logic              oeN;
        logic              weN;
        logic              rstN;
        logic              rstHv;
        logic              oeHv;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dout;
        logic              doutEn;
    } pins_t;

    typedef enum logic [10:0] {
        S_IDLE   = 11'h001,
        S_RD     = 11'h002,
        S_WR     = 11'h004,
        S_GAP    = 11'h008,
        S_POLL   = 11'h010,
        S_RSTLO  = 11'h020,
        S_RSTWT  = 11'h040,
        S_HVSET  = 11'h080,
        S_WEPUL  = 11'h100,
        S_HVEND  = 11'h200,
        S_SUSPD  = 11'h400
    } state_t;

endpackage

// *** test_flash_host.sv ***
`timescale 1ns/1ps
// ****************************************
// flash host bench
// ****************************************
module test_flash_host;
    localparam int SUSPA = 30;
    localparam int SUSPB = 60;
    logic                  ref_clk   = 1'h0;
    logic                  sys_rst   = 1'h1;
    logic                  reqValid  = 1'h0;
    flash_host_pkg::req_t  req       = '0;
    logic                  algoGo    = 1'h0;
    logic                  algoErase = 1'h0;
    logic [15:0]           algoReads = 16'h0;
    logic                  reqReady, doneValid, doneOk, gotOk;
    logic [7:0]            doneData, flashDin, gotData;
    flash_host_pkg::pins_t pins;
    int num_errors = 0;
    int cmp_count  = 0;
    int took = 0, weFalls = 0, weRun = 0, weLast = 0;
    flash_host #(.RST_BUSY_CYC(50), .PROT_CYC(10), .UNPROT_CYC(20), .SUSP_A_CYC(SUSPA),
        .SUSP_B_CYC(SUSPB), .POLL_MAX(64)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .reqValid(reqValid), .req(req), .reqReady(reqReady), .doneValid(doneValid),
        .doneData(doneData), .doneOk(doneOk), .pins(pins), .flashDin(flashDin));
    flash_dev_model dev (.ref_clk(ref_clk), .pins(pins), .flashDin(flashDin),
        .algoGo(algoGo), .algoErase(algoErase), .algoReads(algoReads));
    initial forever #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (pins.weN === 1'h0) begin
            weRun <= weRun + 1;
        end else if (weRun != 0) begin
            weLast  <= weRun;
            weFalls <= weFalls + 1;
            weRun   <= 0;
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic do_req(input flash_host_pkg::op_t op, input logic [18:0] a,
                          input logic [7:0] d, input logic [2:0] f);
        took = 0;
        @(posedge ref_clk);
        reqValid <= 1'h1;
        req      <= '{op, a, d, f[2], f[1], f[0]};
        do @(negedge ref_clk); while (reqReady !== 1'h1);
        @(posedge ref_clk);
        reqValid <= 1'h0;
        do begin
            @(negedge ref_clk);
            took++;
        end while (doneValid !== 1'h1 && took < 3000);
        gotData = doneData;
        gotOk   = doneOk;
        if (took >= 3000) check(16'h0, 16'h1);
    endtask
    task automatic start_algo(input logic erase, input logic [15:0] reads);
        @(posedge ref_clk);
        algoGo    <= 1'h1;
        algoErase <= erase;
        algoReads <= reads;
        @(posedge ref_clk);
        algoGo    <= 1'h0;
    endtask
    task automatic t_prog();
        do_req(flash_host_pkg::OP_WRITE, 19'h2A05C, 8'h5B, 3'h0);
        start_algo(1'h0, 16'h3);
        do_req(flash_host_pkg::OP_POLL_PROG, 19'h2A05C, 8'h5B, 3'h0);
        check({15'h0, gotOk}, 16'h1);
        check({8'h0, gotData}, 16'h005B);
        do_req(flash_host_pkg::OP_READ, 19'h2A001, 8'h00, 3'h0);
        check({8'h0, gotData}, 16'h005B);
    endtask
    task automatic t_erase();
        do_req(flash_host_pkg::OP_WRITE, 19'h4F000, 8'h30, 3'h0);
        start_algo(1'h1, 16'h5);
        do_req(flash_host_pkg::OP_POLL_ERAS, 19'h4F123, 8'h00, 3'h0);
        check({7'h0, gotOk, gotData}, 16'h01FF);
        do_req(flash_host_pkg::OP_READ, 19'h50077, 8'h00, 3'h0);
        check({8'h0, gotData}, 16'h0077);
    endtask
    task automatic t_toggle();
        do_req(flash_host_pkg::OP_WRITE, 19'h13000, 8'hC7, 3'h0);
        start_algo(1'h0, 16'h4);
        do_req(flash_host_pkg::OP_TOGGLE, 19'h00042, 8'h00, 3'h0);
        check({7'h0, gotOk, gotData}, 16'h0142);
        do_req(flash_host_pkg::OP_READ, 19'h13010, 8'h00, 3'h0);
        check({8'h0, gotData}, 16'h00C7);
    endtask
    task automatic t_abort();
        do_req(flash_host_pkg::OP_WRITE, 19'h66000, 8'h81, 3'h0);
        start_algo(1'h0, 16'h1000);
        do_req(flash_host_pkg::OP_POLL_PROG, 19'h66000, 8'h81, 3'h0);
        check({15'h0, gotOk}, 16'h0);
        do_req(flash_host_pkg::OP_RESET, 19'h0, 8'h00, 3'h1);
        check({15'h0, took > flash_host_pkg::RST_PULSE_CYC + 32}, 16'h1);
        do_req(flash_host_pkg::OP_READ, 19'h66000, 8'h00, 3'h0);
        check({8'h0, gotData}, 16'h00C7);
        do_req(flash_host_pkg::OP_RESET, 19'h0, 8'h00, 3'h0);
        check({15'h0, took < flash_host_pkg::RST_PULSE_CYC + 32}, 16'h1);
    endtask
    task automatic t_protect();
        do_req(flash_host_pkg::OP_PROTECT, 19'h3F000, 8'h00, 3'h0);
        check({15'h0, weLast >= 10}, 16'h1);
        check({15'h0, took > 2 * flash_host_pkg::HV_SETUP_CYC}, 16'h1);
        do_req(flash_host_pkg::OP_UNPROTECT, 19'h3F000, 8'h00, 3'h0);
        check({15'h0, weLast >= 20}, 16'h1);
    endtask
    task automatic t_suspend();
        int falls;
        for (int v = 0; v < 2; v++) begin
            falls = weFalls;
            for (int i = 0; i < 1024; i++) do_req(flash_host_pkg::OP_WRITE, 19'h00555, 8'hB0, 3'h4);
            do_req(flash_host_pkg::OP_WRITE, 19'h00555, 8'hB0, {1'h1, v[0], 1'h0});
            check({15'h0, took >= (v == 1 ? SUSPB : SUSPA)}, 16'h1);
            check(16'(weFalls - falls), 16'h0400);
        end
    endtask
    initial begin
        repeat (60000) @(posedge ref_clk);
        num_errors++;
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'h0;
        t_prog();
        t_erase();
        t_toggle();
        t_abort();
        t_protect();
        t_suspend();
        print_verdict();
    end
endmodule // test_flash_host
